// [hdl/usbep_dev.sv]
// Function
// - auto-set raises tx ready on full packet
// - software raises tx ready for short packets
// - in bit 6 selects isochronous handling
// - in bit 5 sets endpoint direction
// - direction only counts on shared-buffer endpoints
// - in bit 4 enables dma request
// - forced toggle flips after every sent packet
// - in bits 2:0 read zero
// - out max size in eights, two means sixteen
// - per nonzero endpoint copies, selected by index
// - out bit 7 zeroes data toggle
// - stall issued flag set, software clears
// - stall request answers out traffic with stall
// - stall request ignored in isochronous mode
// - out bit 4 discards next packet, self-clears
// - software flushes twice for two packets
// - crc/stuff fault set with rx ready on isochronous endpoints only
// - iso overrun flag set, software clears
// - full flag follows buffer no-room state
// - rx ready set with interrupt
// - software clears rx ready after reading
// - software sets tx ready, device clears after send
`include "usbep_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module usbep_dev #(
    parameter int NUM_EP = 4,
    parameter int EP_W = 2,
    parameter logic [NUM_EP-1:0] SHARED_MASK = '0
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // register path
    usbep_reg_if.dev bus,
    // usb engine events
    input wire logic [EP_W-1:0] ev_ep_in,
    input wire logic in_load_done_in,
    input wire logic [10:0] in_fill_bytes_in,
    input wire logic [10:0] in_max_bytes_in,
    input wire logic in_sent_in,
    input wire logic in_acked_in,
    input wire logic rx_done_in,
    input wire logic rx_crc_err_in,
    input wire logic rx_nostore_in,
    input wire logic stall_sent_in,
    input wire logic [NUM_EP-1:0] rx_full_in,
    input wire logic [NUM_EP-1:0] out_iso_in,
    // endpoint controls to the usb engine
    output logic [NUM_EP-1:0] in_iso_out,
    output logic [NUM_EP-1:0] in_dir_is_in_out,
    output logic [NUM_EP-1:0] dma_req_out,
    output logic [NUM_EP-1:0] in_toggle_out,
    output logic [NUM_EP-1:0] out_toggle_out,
    output logic [NUM_EP-1:0] tx_ready_out,
    output logic [NUM_EP-1:0] out_stall_out,
    output logic [NUM_EP-1:0] discard_out,
    output logic [NUM_EP*11-1:0] out_max_bytes_out,
    output logic rx_irq_out
);
    import usbep_pkg::*;

    // address decode
    wire hit_in2 = (bus.addr == `USBEP_IN_CTRL_TWO_OFS);
    wire hit_maxp = (bus.addr == `USBEP_OUT_MAXP_OFS);
    wire hit_out1 = (bus.addr == `USBEP_OUT_CTRL_ONE_OFS);

    wire [7:0] rd_in2 [NUM_EP];
    wire [7:0] rd_maxp [NUM_EP];
    wire [7:0] rd_out1 [NUM_EP];

    logic [7:0] rdata_q;
    logic rx_irq_q;

    genvar i;
    generate
        for (i = 0; i < NUM_EP; i++)
        begin : g_ep
            wire sel = (bus.ep_sel == EP_W'(i)) && (i != 0);
            wire ev = (ev_ep_in == EP_W'(i)) && (i != 0);
            wire we_in2 = bus.wr && hit_in2 && sel;
            wire we_maxp = bus.wr && hit_maxp && sel;
            wire we_out1 = bus.wr && hit_out1 && sel;

            logic [7:0] ctrl_q;
            logic [7:0] maxp_q;
            logic stall_req_q;
            logic stall_iss_q;
            logic rx_rdy_q;
            logic err_q;
            logic undr_q;
            logic tx_rdy_q;
            logic in_tog_q;
            logic out_tog_q;
            logic disc_q;

            // automatic tx ready on a full-sized load
            wire auto_set = ev && in_load_done_in && ctrl_q[`USBEP_IN2_AUTO_BIT] &&
                            (in_fill_bytes_in == in_max_bytes_in);
            // software set and clear after transmit
            wire tx_set = (bus.tx_ready_set && sel) || auto_set;
            wire tx_clr = ev && in_sent_in;
            wire rx_set = ev && rx_done_in;
            // only a one clears the flags
            wire rx_clr = we_out1 && bus.wdata[`USBEP_OUT1_RDY_BIT];
            wire siss_clr = we_out1 && bus.wdata[`USBEP_OUT1_SISS_BIT];
            wire undr_clr = we_out1 && bus.wdata[`USBEP_OUT1_UNDR_BIT];
            wire undr_set = ev && rx_nostore_in && out_iso_in[i];
            wire in_flip = tx_clr && (in_acked_in || ctrl_q[`USBEP_IN2_FRC_BIT]);

            // control registers
            always_ff @(posedge core_clk_in)
            begin
                if (!resetn_in)
                begin
                    ctrl_q <= `USBEP_IN2_RST;
                    maxp_q <= `USBEP_MAXP_RST;
                    stall_req_q <= 1'b0;
                end
                else
                begin
                    if (we_in2)
                        ctrl_q <= bus.wdata & `USBEP_IN2_WMASK;
                    if (we_maxp)
                        maxp_q <= bus.wdata;
                    if (we_out1)
                        stall_req_q <= bus.wdata[`USBEP_OUT1_SREQ_BIT];
                end
            end

            // status flags, a set beats a clear in the same cycle
            always_ff @(posedge core_clk_in)
            begin
                if (!resetn_in)
                begin
                    stall_iss_q <= 1'b0;
                    rx_rdy_q <= 1'b0;
                    undr_q <= 1'b0;
                    tx_rdy_q <= 1'b0;
                end
                else
                begin
                    stall_iss_q <= (ev && stall_sent_in) || (stall_iss_q && !siss_clr);
                    rx_rdy_q <= rx_set || (rx_rdy_q && !rx_clr);
                    undr_q <= undr_set || (undr_q && !undr_clr);
                    tx_rdy_q <= tx_set || (tx_rdy_q && !tx_clr);
                end
            end

            // fault latched with rx ready, dropped with it
            always_ff @(posedge core_clk_in)
            begin
                if (!resetn_in)
                    err_q <= 1'b0;
                else if (rx_set)
                    err_q <= rx_crc_err_in && out_iso_in[i];
                else if (rx_clr)
                    err_q <= 1'b0;
            end

            // data toggles and discard pulse
            always_ff @(posedge core_clk_in)
            begin
                if (!resetn_in)
                begin
                    in_tog_q <= 1'b0;
                    out_tog_q <= 1'b0;
                    disc_q <= 1'b0;
                end
                else
                begin
                    if (in_flip)
                        in_tog_q <= !in_tog_q;
                    // zero command wins over a flip
                    if (we_out1 && bus.wdata[`USBEP_OUT1_TOGZ_BIT])
                        out_tog_q <= 1'b0;
                    else if (rx_set && !rx_crc_err_in)
                        out_tog_q <= !out_tog_q;
                    disc_q <= we_out1 && bus.wdata[`USBEP_OUT1_DISC_BIT];
                end
            end

            assign in_iso_out[i] = ctrl_q[`USBEP_IN2_ISO_BIT];
            // fixed to in unless buffer is shared
            assign in_dir_is_in_out[i] = SHARED_MASK[i] ? ctrl_q[`USBEP_IN2_DIR_BIT] : 1'b1;
            // dma request while buffer awaits data
            assign dma_req_out[i] = ctrl_q[`USBEP_IN2_DMA_BIT] && !tx_rdy_q && in_dir_is_in_out[i];
            assign in_toggle_out[i] = in_tog_q;
            assign out_toggle_out[i] = out_tog_q;
            assign tx_ready_out[i] = tx_rdy_q;
            assign out_stall_out[i] = stall_req_q && !out_iso_in[i];
            assign discard_out[i] = disc_q;
            // units of eight bytes, two is sixteen
            assign out_max_bytes_out[i*11 +: 11] = (maxp_q == `USBEP_MAXP_SPECIAL) ?
                `USBEP_MAXP_SPECIAL_BYTES : {maxp_q, 3'b000};

            // readback images
            assign rd_in2[i] = {ctrl_q[7:3], 3'b000};
            assign rd_maxp[i] = maxp_q;
            // full follows the buffer state, endpoint 0 reads zero
            assign rd_out1[i] = {1'b0, stall_iss_q, stall_req_q, 1'b0, err_q, undr_q,
                                 (i != 0) && rx_full_in[i], rx_rdy_q};
        end
    endgenerate

    // read mux, unmapped addresses read zero
    wire [7:0] rd_mux = hit_in2 ? rd_in2[bus.ep_sel] :
                        hit_maxp ? rd_maxp[bus.ep_sel] :
                        hit_out1 ? rd_out1[bus.ep_sel] : 8'h00;

    // read data and interrupt pulse
    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            rdata_q <= 8'h00;
            rx_irq_q <= 1'b0;
        end
        else
        begin
            if (bus.rd)
                rdata_q <= rd_mux;
            rx_irq_q <= rx_done_in && (ev_ep_in != '0);
        end
    end

    assign bus.rdata = rdata_q;
    assign rx_irq_out = rx_irq_q;

endmodule : usbep_dev

`default_nettype wire

// [hdl/usbep_defines.svh]
`ifndef USBEP_DEFINES_SVH
`define USBEP_DEFINES_SVH

// register offsets
`define USBEP_IN_CTRL_TWO_OFS 16'hC012
`define USBEP_OUT_MAXP_OFS 16'hC013
`define USBEP_OUT_CTRL_ONE_OFS 16'hC014

// in_endpoint_control_two fields
`define USBEP_IN2_AUTO_BIT 7
`define USBEP_IN2_ISO_BIT 6
`define USBEP_IN2_DIR_BIT 5
`define USBEP_IN2_DMA_BIT 4
`define USBEP_IN2_FRC_BIT 3
`define USBEP_IN2_WMASK 8'hF8

// out_endpoint_control_one fields
`define USBEP_OUT1_TOGZ_BIT 7
`define USBEP_OUT1_SISS_BIT 6
`define USBEP_OUT1_SREQ_BIT 5
`define USBEP_OUT1_DISC_BIT 4
`define USBEP_OUT1_ERR_BIT 3
`define USBEP_OUT1_UNDR_BIT 2
`define USBEP_OUT1_FULL_BIT 1
`define USBEP_OUT1_RDY_BIT 0
`define USBEP_OUT1_KEEP_MASK 8'h20

// command values written by the cpu end
`define USBEP_OUT1_DISC_CMD 8'h10
`define USBEP_OUT1_RDY_CLR 8'h01

// reset values
`define USBEP_IN2_RST 8'h00
`define USBEP_MAXP_RST 8'h00
`define USBEP_OUT1_RST 8'h00

// max packet size decoding
`define USBEP_MAXP_SPECIAL 8'h02
`define USBEP_MAXP_SPECIAL_BYTES 11'h010
`define USBEP_MAXP_UNIT_SHIFT 3

`endif

// [hdl/usbep_pkg.sv]
`default_nettype none

package usbep_pkg;

    // operations of the cpu end command port
    typedef enum logic [2:0] {
        USBEP_OP_WRITE,
        USBEP_OP_READ,
        USBEP_OP_TX_READY,
        USBEP_OP_FLUSH_ALL,
        USBEP_OP_RX_RELEASE
    } usbep_op_t;

    // cpu end sequencer states
    typedef enum logic [2:0] {
        USBEP_ST_IDLE,
        USBEP_ST_READ,
        USBEP_ST_HOLD,
        USBEP_ST_WRITE,
        USBEP_ST_WRITE2,
        USBEP_ST_DONE
    } usbep_state_t;

endpackage : usbep_pkg

`default_nettype wire

// [hdl/usbep_reg_if.sv]
`timescale 1ns/1ps
`default_nettype none

// register path between the cpu end and the endpoint logic
interface usbep_reg_if #(
    parameter int EP_W = 2
);
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [EP_W-1:0] ep_sel;
    logic tx_ready_set;

    modport dev (
        input addr,
        input wr,
        input rd,
        input wdata,
        input ep_sel,
        input tx_ready_set,
        output rdata
    );

    modport cpu (
        output addr,
        output wr,
        output rd,
        output wdata,
        output ep_sel,
        output tx_ready_set,
        input rdata
    );
endinterface : usbep_reg_if

`default_nettype wire

// [hdl/usbep_cpu.sv]
`include "usbep_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module usbep_cpu #(
    parameter int EP_W = 2
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // register path
    usbep_reg_if.cpu bus,
    // command port
    input wire logic cmd_valid_in,
    input wire usbep_pkg::usbep_op_t cmd_op_in,
    input wire logic [EP_W-1:0] cmd_ep_in,
    input wire logic [15:0] cmd_addr_in,
    input wire logic [7:0] cmd_data_in,
    output logic cmd_ready_out,
    // response port
    output logic rsp_valid_out,
    output logic [7:0] rsp_data_out
);
    import usbep_pkg::*;

    usbep_state_t state_q;
    usbep_op_t op_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [EP_W-1:0] sel_q;
    logic wr_q;
    logic rd_q;
    logic set_q;
    logic [7:0] rsp_q;

    // value kept when commanding out control one: stall request only
    wire [7:0] keep = bus.rdata & `USBEP_OUT1_KEEP_MASK;
    wire rmw = (cmd_op_in == USBEP_OP_FLUSH_ALL) || (cmd_op_in == USBEP_OP_RX_RELEASE);

    // sequencer
    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            state_q <= USBEP_ST_IDLE;
            op_q <= USBEP_OP_WRITE;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            sel_q <= '0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            set_q <= 1'b0;
            rsp_q <= 8'h00;
        end
        else
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            set_q <= 1'b0;
            case (state_q)
                USBEP_ST_IDLE:
                begin
                    if (cmd_valid_in)
                    begin
                        op_q <= cmd_op_in;
                        sel_q <= cmd_ep_in;
                        wdata_q <= cmd_data_in;
                        addr_q <= rmw ? `USBEP_OUT_CTRL_ONE_OFS : cmd_addr_in;
                        case (cmd_op_in)
                            USBEP_OP_WRITE:
                            begin
                                wr_q <= 1'b1;
                                state_q <= USBEP_ST_DONE;
                            end
                            // software marks a loaded packet ready
                            // set after the buffer is written
                            USBEP_OP_TX_READY:
                            begin
                                set_q <= 1'b1;
                                state_q <= USBEP_ST_DONE;
                            end
                            default:
                            begin
                                rd_q <= 1'b1;
                                state_q <= USBEP_ST_READ;
                            end
                        endcase
                    end
                end
                USBEP_ST_READ:
                    state_q <= USBEP_ST_HOLD;
                USBEP_ST_HOLD:
                begin
                    rsp_q <= bus.rdata;
                    if (op_q == USBEP_OP_READ)
                        state_q <= USBEP_ST_DONE;
                    else
                    begin
                        wr_q <= 1'b1;
                        wdata_q <= keep | ((op_q == USBEP_OP_FLUSH_ALL) ?
                                   `USBEP_OUT1_DISC_CMD : `USBEP_OUT1_RDY_CLR);
                        state_q <= USBEP_ST_WRITE;
                    end
                end
                USBEP_ST_WRITE:
                begin
                    // second discard empties a two-packet buffer
                    if (op_q == USBEP_OP_FLUSH_ALL)
                    begin
                        wr_q <= 1'b1;
                        state_q <= USBEP_ST_WRITE2;
                    end
                    else
                        state_q <= USBEP_ST_DONE;
                end
                USBEP_ST_WRITE2:
                    state_q <= USBEP_ST_DONE;
                USBEP_ST_DONE:
                    state_q <= USBEP_ST_IDLE;
                default:
                    state_q <= USBEP_ST_IDLE;
            endcase
        end
    end

    // bus and handshake outputs
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.ep_sel = sel_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
    assign bus.tx_ready_set = set_q;
    assign cmd_ready_out = (state_q == USBEP_ST_IDLE);
    assign rsp_valid_out = (state_q == USBEP_ST_DONE);
    assign rsp_data_out = rsp_q;

endmodule : usbep_cpu

`default_nettype wire

// [verification/usbep_chk_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

// watches the register path and the endpoint outputs
module usbep_chk #(
    parameter int NUM_EP = 4,
    parameter int EP_W = 2
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // register path
    input wire logic [15:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [EP_W-1:0] ep_sel,
    input wire logic tx_ready_set,
    // engine side
    input wire logic [EP_W-1:0] ev_ep_in,
    input wire logic rx_done_in,
    input wire logic [NUM_EP-1:0] out_iso_in,
    input wire logic [NUM_EP-1:0] tx_ready_out,
    input wire logic [NUM_EP-1:0] out_stall_out,
    input wire logic [NUM_EP-1:0] discard_out,
    input wire logic [NUM_EP*11-1:0] out_max_bytes_out,
    input wire logic rx_irq_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    // read and write side effects, receive interrupt and stall checks
    property p_in2_low_zero;
        rd && addr == 16'hC012 |=> rdata[2:0] == 3'h0;
    endproperty
    property p_no_sel;
        rd && ep_sel == 0 |=> rdata == 8'h00;
    endproperty
    property p_disc_set;
        wr && ep_sel == 1 && addr == 16'hC014 && wdata[4] |=> discard_out[1];
    endproperty
    property p_disc_cause;
        discard_out[1] |-> $past(wr && ep_sel == 1 && addr == 16'hC014 && wdata[4]);
    endproperty
    property p_irq_set;
        rx_done_in && ev_ep_in != 0 |=> rx_irq_out;
    endproperty
    property p_irq_cause;
        rx_irq_out |-> $past(rx_done_in && ev_ep_in != 0);
    endproperty
    property p_stall_iso;
        out_stall_out[1] |-> !out_iso_in[1];
    endproperty
    property p_txr_set;
        tx_ready_set && ep_sel == 1 |=> tx_ready_out[1];
    endproperty
    property p_maxp16;
        wr && ep_sel == 1 && addr == 16'hC013 && wdata == 8'h02 |=> out_max_bytes_out[21:11] == 11'h010;
    endproperty

    a_in2_low_zero: assert property (p_in2_low_zero) else $error("low bits of in control two not zero");
    a_no_sel: assert property (p_no_sel) else $error("read with no endpoint selected not zero");
    a_disc_set: assert property (p_disc_set) else $error("discard pulse missing");
    a_disc_cause: assert property (p_disc_cause) else $error("discard pulse without command");
    a_irq_set: assert property (p_irq_set) else $error("receive interrupt missing");
    a_irq_cause: assert property (p_irq_cause) else $error("receive interrupt without packet");
    a_stall_iso: assert property (p_stall_iso) else $error("stall driven in isochronous mode");
    a_txr_set: assert property (p_txr_set) else $error("tx ready not set");
    a_maxp16: assert property (p_maxp16) else $error("size two not sixteen bytes");

    // main scenarios reached
    c_disc: cover property (discard_out[1]);
    c_irq: cover property (rx_irq_out);
    c_stall: cover property (out_stall_out[1]);
endmodule : usbep_chk

`default_nettype wire

// [verification/tb_usb_endpoint_ctrl_status.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_usb_endpoint_ctrl_status;
    import usbep_pkg::*;
    // stimulus and observed signals
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cmd_valid = 1'b0;
    usbep_op_t cmd_op = USBEP_OP_WRITE;
    logic [1:0] cmd_ep = 2'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, rsp_valid, irq;
    logic [7:0] rsp_data;
    logic [1:0] ev_ep = 2'h0;
    logic [4:0] evp = 5'h00; // load, sent, rx, nostore, stall
    logic acked = 1'b0;
    logic crc = 1'b0;
    logic [10:0] fill = 11'h010;
    logic [10:0] in_max = 11'h010;
    logic [3:0] rx_full = 4'h0;
    logic [3:0] out_iso = 4'h0;
    logic [3:0] in_iso, dir_in, dma_req, in_tog, out_tog, tx_rdy, stall, disc;
    logic [43:0] max_bytes;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    int disc_cnt = 0;
    int irq_cnt = 0;

    // clock
    initial
    begin
        forever #5 core_clk_in = ~core_clk_in;
    end

    usbep_reg_if usbep_reg_if_i ();
    usbep_dev #(.SHARED_MASK(4'h4)) usbep_dev_i (.core_clk_in(core_clk_in),
        .resetn_in(resetn_in), .bus(usbep_reg_if_i.dev), .ev_ep_in(ev_ep), .in_load_done_in(evp[0]),
        .in_fill_bytes_in(fill), .in_max_bytes_in(in_max), .in_sent_in(evp[1]), .in_acked_in(acked),
        .rx_done_in(evp[2]), .rx_crc_err_in(crc), .rx_nostore_in(evp[3]), .stall_sent_in(evp[4]),
        .rx_full_in(rx_full), .out_iso_in(out_iso), .in_iso_out(in_iso), .in_dir_is_in_out(dir_in),
        .dma_req_out(dma_req), .in_toggle_out(in_tog), .out_toggle_out(out_tog), .tx_ready_out(tx_rdy),
        .out_stall_out(stall), .discard_out(disc), .out_max_bytes_out(max_bytes), .rx_irq_out(irq));
    usbep_cpu usbep_cpu_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .bus(usbep_reg_if_i.cpu), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_ep_in(cmd_ep),
        .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
        .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data));
    usbep_chk usbep_chk_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .addr(usbep_reg_if_i.addr), .wr(usbep_reg_if_i.wr), .rd(usbep_reg_if_i.rd),
        .wdata(usbep_reg_if_i.wdata), .rdata(usbep_reg_if_i.rdata), .ep_sel(usbep_reg_if_i.ep_sel),
        .tx_ready_set(usbep_reg_if_i.tx_ready_set), .ev_ep_in(ev_ep), .rx_done_in(evp[2]),
        .out_iso_in(out_iso), .tx_ready_out(tx_rdy), .out_stall_out(stall), .discard_out(disc),
        .out_max_bytes_out(max_bytes), .rx_irq_out(irq));

    // pulse counters and hang guard
    always @(posedge core_clk_in)
    begin
        disc_cnt <= disc_cnt + int'(disc[1] === 1'b1);
        irq_cnt <= irq_cnt + int'(irq === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // one command, offered for one cycle after checking ready is high, then wait for its response
    task automatic cmd(input usbep_op_t op, input logic [1:0] ep, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        chk(16'(cmd_ready), 16'h0001);
        cmd_op = op;
        cmd_ep = ep;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(posedge core_clk_in);
        #1 cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 20)
        begin
            @(posedge core_clk_in);
            #1 n++;
        end
        chk(16'(n == 20), 16'h0000);
        @(posedge core_clk_in);
        #1;
    endtask : cmd

    task automatic rdc(input logic [1:0] ep, input logic [15:0] a, input logic [7:0] exp);
        cmd(USBEP_OP_READ, ep, a, 8'h00);
        chk(16'(rsp_data), 16'(exp));
    endtask : rdc

    task automatic ev(input logic [1:0] ep, input logic [4:0] p);
        ev_ep = ep;
        evp = p;
        @(posedge core_clk_in);
        #1 evp = 5'h00;
        @(posedge core_clk_in);
        #1;
    endtask : ev

    task automatic t_in_ctrl();
        rdc(1, 16'hC014, 8'h00);
        cmd(USBEP_OP_WRITE, 1, 16'hC012, 8'hFF);
        cmd(USBEP_OP_WRITE, 2, 16'hC012, 8'hDF);
        cmd(USBEP_OP_WRITE, 3, 16'hC012, 8'h00);
        rdc(1, 16'hC012, 8'hF8);
        chk(16'(in_iso), 16'h0006);
        chk(16'(dir_in), 16'h000B);
        chk(16'(dma_req), 16'h0002);
        cmd(USBEP_OP_WRITE, 2, 16'hC012, 8'h20);
        chk(16'(dir_in), 16'h000F);
    endtask : t_in_ctrl

    task automatic t_maxp();
        rdc(1, 16'hC013, 8'h00);
        cmd(USBEP_OP_WRITE, 1, 16'hC013, 8'h02);
        cmd(USBEP_OP_WRITE, 2, 16'hC013, 8'h03);
        cmd(USBEP_OP_WRITE, 0, 16'hC013, 8'h05);
        rdc(1, 16'hC013, 8'h02);
        rdc(0, 16'hC013, 8'h00);
        rdc(1, 16'hC015, 8'h00);
        chk(16'(max_bytes[21:11]), 16'h0010);
        chk(16'(max_bytes[32:22]), 16'h0018);
    endtask : t_maxp

    task automatic t_tx();
        ev(1, 5'h01);
        chk(16'({tx_rdy[1], dma_req[1]}), 16'h0002);
        ev(1, 5'h02);
        chk(16'({tx_rdy[1], in_tog[1]}), 16'h0001);
        fill = 11'h008;
        ev(1, 5'h01);
        chk(16'(tx_rdy[1]), 16'h0000);
        cmd(USBEP_OP_TX_READY, 1, 16'hC012, 8'h00);
        chk(16'(tx_rdy[1]), 16'h0001);
        cmd(USBEP_OP_WRITE, 1, 16'hC012, 8'h80);
        ev(1, 5'h02);
        chk(16'({tx_rdy[1], in_tog[1]}), 16'h0001);
        acked = 1'b1;
        ev(1, 5'h02);
        chk(16'(in_tog[1]), 16'h0000);
    endtask : t_tx

    task automatic t_out();
        int disc_base;
        ev(1, 5'h04);
        rdc(1, 16'hC014, 8'h01);
        chk(16'({irq_cnt[3:0], out_tog[1]}), 16'h0003);
        rx_full = 4'h2;
        rdc(1, 16'hC014, 8'h03);
        rx_full = 4'h0;
        ev(1, 5'h10);
        cmd(USBEP_OP_WRITE, 1, 16'hC014, 8'h00);
        rdc(1, 16'hC014, 8'h41);
        cmd(USBEP_OP_WRITE, 1, 16'hC014, 8'h40);
        rdc(1, 16'hC014, 8'h01);
        cmd(USBEP_OP_WRITE, 1, 16'hC014, 8'h20);
        chk(16'(stall[1]), 16'h0001);
        out_iso = 4'h2;
        @(posedge core_clk_in);
        #1 chk(16'(stall[1]), 16'h0000);
        crc = 1'b1;
        ev(1, 5'h08);
        ev(1, 5'h04);
        rdc(1, 16'hC014, 8'h2D);
        chk(16'(out_tog[1]), 16'h0001);
        cmd(USBEP_OP_RX_RELEASE, 1, 16'hC014, 8'h00);
        rdc(1, 16'hC014, 8'h24);
        cmd(USBEP_OP_WRITE, 1, 16'hC014, 8'hA4);
        rdc(1, 16'hC014, 8'h20);
        chk(16'(out_tog[1]), 16'h0000);
        disc_base = disc_cnt;
        cmd(USBEP_OP_FLUSH_ALL, 1, 16'hC014, 8'h00);
        cmd(USBEP_OP_WRITE, 1, 16'hC014, 8'h00);
        chk(16'(disc_cnt - disc_base), 16'h0002);
    endtask : t_out

    // reset, then the scenarios
    initial
    begin
        repeat (16) @(posedge core_clk_in);
        #1 resetn_in = 1'b1;
        t_in_ctrl();
        t_maxp();
        t_tx();
        t_out();
        conclude();
    end
endmodule : tb_usb_endpoint_ctrl_status

`default_nettype wire
